// file: logic/hbgc_pkg.sv
// Purpose: Types shared by the gate control block
// Assumes: Constants come from hbgc_regs.svh
// Notes: Pins carry a level and a floating indication
`default_nettype none
package hbgc_pkg;

  // One input pin: level plus not-driven flag
  typedef struct packed {
    logic lvl;
    logic flt;
  } hbgc_pin_t;

  // Control pins from the host
  typedef struct packed {
    hbgc_pin_t enable;
    hbgc_pin_t disable_hi_active;
    hbgc_pin_t disable_lo_active;
    hbgc_pin_t half_bridge_a_cmd;
    hbgc_pin_t half_bridge_b_cmd;
    hbgc_pin_t polarity_swap;
  } hbgc_pins_t;

  // Analog comparator results
  typedef struct packed {
    logic uv;        // Supply below lockout
    logic cur_over;  // Load current at selected limit
    logic temp_fold; // Junction above foldback point
    logic temp_shut; // Junction above shutdown point
    logic temp_cool; // Junction below shutdown minus hysteresis
  } hbgc_sense_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hbgc_bus_t;

  // Bridge drive, level and enable per half
  typedef struct packed {
    logic oe_a;
    logic lvl_a;
    logic oe_b;
    logic lvl_b;
  } hbgc_drive_t;

  // Output stage states
  typedef enum logic [5:0] {
    HBGC_SLEEP = 6'b000001,
    HBGC_UVLO = 6'b000010,
    HBGC_LATCHED = 6'b000100,
    HBGC_DISABLED = 6'b001000,
    HBGC_OFFTIME = 6'b010000,
    HBGC_DRIVE = 6'b100000
  } hbgc_state_t;

endpackage
`default_nettype wire

// file: logic/hbgc_regs.svh
// Purpose: Constants of the H-bridge gate control and fault latch block
// Assumes: 100 MHz core clock, 32-bit register port with byte offsets
// Notes: Functional notes below; numbers used once, by name
//
// Functional notes
// R01: Enabled, undisabled outputs follow their commands
// R02: Polarity swap inverts both command inputs
// R03: Either disable input tri-states both outputs
// R04: Enable low: sleep, outputs off, flag released
// R05: Awake and disabled: flag low, outputs off
// R06: Floating inputs take their documented default levels
// R07: Undervoltage: outputs off, flag low, self-recovering
// R08: Short or overtemperature latches outputs off, flag low
// R09: Disable falling/rising clear edge releases the latch
// R10: After clear, outputs take commanded state again
// R11: Current limit: fixed 20 us off-time, then resume
// R12: Above 160 C select reduced 4.2 A limit
// R13: Above 175 C latched overtemperature shutdown
// R14: Overtemperature clears only once cooled below hysteresis
// R15: Clearing clears flag; power cycle also resets
// R16: Output transition starts blanking: short versus limit
`ifndef HBGC_REGS_SVH
`define HBGC_REGS_SVH

// Timing
`define HBGC_CLK_NS 10
`define HBGC_TOFF_US 20
`define HBGC_TOFF_CYC ((`HBGC_TOFF_US * 1000) / `HBGC_CLK_NS)
`define HBGC_BLANK_NS 1000
`define HBGC_BLANK_CYC ((`HBGC_BLANK_NS) / `HBGC_CLK_NS)
`define HBGC_TMR_W 12

// Register offsets
`define HBGC_ADDR_STATUS 8'h00
`define HBGC_ADDR_MASK 8'h04
`define HBGC_ADDR_STATE 8'h08

// Event bit positions in status and mask
`define HBGC_EV_UV 0
`define HBGC_EV_SC 1
`define HBGC_EV_OT 2
`define HBGC_EV_CURRENT_LIMIT_THRESHOLD 3
`define HBGC_EV_CLR 4
`define HBGC_EV_W 5

// Reset values
`define HBGC_STATUS_RST 5'h00
`define HBGC_MASK_RST 5'h00

`endif

// file: logic/hbgc_timer.sv
// Purpose: Load-and-count-down window timer
// Assumes: LEN fits the counter width
// Notes: busy is high for exactly LEN cycles after a load
`timescale 1ns/1ns
`default_nettype none
module hbgc_timer #(
  parameter int W = 12,
  parameter int LEN = 2000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  output logic busy
);

  ////////////////////////////////////////////////////////////////
  // Parameter check
  if (LEN < 1 || LEN >= (1 << W)) begin : g_len_bad
    $error("hbgc_timer: LEN does not fit counter");
  end

  logic [W-1:0] cnt_ff; // Remaining cycles
  logic [W-1:0] nxt_cnt;

  ////////////////////////////////////////////////////////////////
  // Next count: reload wins over counting
  always_comb begin
    if (load) begin
      nxt_cnt = LEN[W-1:0];
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // Count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != '0);

endmodule
`default_nettype wire

// file: logic/hbgc_top.sv
// Purpose: Gate control and fault latch of a DC-motor H-bridge
// Assumes: Pins and sense inputs synchronous to clk; rst is power-on
// Notes: Registers hold event status, mask and a read-only state view
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "hbgc_regs.svh"
module hbgc_top
  import hbgc_pkg::*;
#(
  parameter int OFF_CYC = `HBGC_TOFF_CYC,
  parameter int BLANK_CYC = `HBGC_BLANK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire hbgc_pins_t pins,
  input wire hbgc_sense_t sense,
  input wire hbgc_bus_t bus,
  output logic [31:0] rdata,
  output logic irq,
  output logic bridge_out_a_o,
  output logic bridge_out_a_oe,
  output logic bridge_out_b_o,
  output logic bridge_out_b_oe,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  output logic current_limit_reduced
);

  ////////////////////////////////////////////////////////////////
  // Off-time timer spans all but the start cycle, so Z lasts OFF_CYC cycles
  localparam int OFF_LEN = OFF_CYC - 1;

  // Parameter check
  if (OFF_CYC < 2 || OFF_LEN >= (1 << `HBGC_TMR_W) ||
      BLANK_CYC < 1 || BLANK_CYC >= (1 << `HBGC_TMR_W)) begin : g_par_bad
    $error("hbgc_top: timing count out of range");
  end

  ////////////////////////////////////////////////////////////////
  // Effective pin levels with floating defaults
  logic en_eff;   // Enable, floats to sleep
  logic d_hi_eff; // High-active disable, floats disabled
  logic d_lo_eff; // Low-active disable, floats disabled
  logic cmd_a_eff; // Command A, floats high
  logic cmd_b_eff; // Command B, floats high
  logic swap_eff;  // Polarity swap, floats non-inverted
  logic disabled;  // Either disable set

  assign en_eff = pins.enable.flt ? 1'b0 : pins.enable.lvl; // [R06]
  assign d_hi_eff = pins.disable_hi_active.flt ? 1'b1 : pins.disable_hi_active.lvl; // [R06]
  assign d_lo_eff = pins.disable_lo_active.flt ? 1'b0 : pins.disable_lo_active.lvl; // [R06]
  assign cmd_a_eff = pins.half_bridge_a_cmd.flt ? 1'b1 : pins.half_bridge_a_cmd.lvl; // [R06]
  assign cmd_b_eff = pins.half_bridge_b_cmd.flt ? 1'b1 : pins.half_bridge_b_cmd.lvl; // [R06]
  assign swap_eff = pins.polarity_swap.flt ? 1'b0 : pins.polarity_swap.lvl; // [R06]
  assign disabled = d_hi_eff | ~d_lo_eff; // [R03]

  ////////////////////////////////////////////////////////////////
  // State, latches and edge history
  hbgc_state_t state_ff; // Output stage state
  hbgc_state_t nxt_state;
  hbgc_drive_t drv_ff; // Registered bridge drive
  hbgc_drive_t nxt_drv;
  logic sc_latched_ff; // Short-circuit latch
  logic nxt_sc_latched;
  logic ot_latched_ff; // Overtemperature latch
  logic nxt_ot_latched;
  logic d_hi_prev_ff; // Last disable levels for edges
  logic d_lo_prev_ff;
  logic flag_low_ff; // Fault flag pulled low
  logic nxt_flag_low;
  logic fold_ff; // Reduced limit selected
  logic clr_edge; // Host clear edge seen
  logic sc_set; // Short detected this cycle
  logic ot_set; // Overtemperature this cycle
  logic off_start; // Start a current-limit off-time
  logic blank_start; // Output transition seen
  logic off_busy; // Off-time running
  logic blank_busy; // Blanking window running
  logic awake_ok; // Enabled with good supply

  assign awake_ok = en_eff & ~sense.uv;
  assign clr_edge = (d_hi_prev_ff & ~d_hi_eff) | (~d_lo_prev_ff & d_lo_eff); // [R09]
  // Limit hit early after a transition is a short, later it is regulated
  assign sc_set = (state_ff == HBGC_DRIVE) & sense.cur_over & blank_busy & awake_ok; // [R16]
  assign off_start = (state_ff == HBGC_DRIVE) & sense.cur_over & ~blank_busy & awake_ok; // [R11]
  assign ot_set = sense.temp_shut & awake_ok; // [R13]

  ////////////////////////////////////////////////////////////////
  // Off-time and blanking timers
  hbgc_timer #(.W(`HBGC_TMR_W), .LEN(OFF_LEN)) u_off_tmr (
    .clk(clk),
    .rst(rst),
    .load(off_start),
    .busy(off_busy)
  );

  hbgc_timer #(.W(`HBGC_TMR_W), .LEN(BLANK_CYC)) u_blank_tmr (
    .clk(clk),
    .rst(rst),
    .load(blank_start),
    .busy(blank_busy)
  );

  ////////////////////////////////////////////////////////////////
  // Fault latches: set wins over clear
  always_comb begin
    nxt_sc_latched = sc_latched_ff;
    nxt_ot_latched = ot_latched_ff;
    // Sleep or supply drop releases both latches
    if (!awake_ok) begin
      nxt_sc_latched = 1'b0; // [R08] [R15]
      nxt_ot_latched = 1'b0; // [R08]
    end else if (clr_edge) begin
      nxt_sc_latched = 1'b0; // [R09]
      // Cooled below hysteresis only
      if (sense.temp_cool) begin
        nxt_ot_latched = 1'b0; // [R14]
      end
    end
    if (sc_set) begin
      nxt_sc_latched = 1'b1; // [R08]
    end
    if (ot_set) begin
      nxt_ot_latched = 1'b1; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////
  // Stage state and drive, by priority
  always_comb begin
    nxt_drv = '0;
    nxt_flag_low = 1'b0;
    // Sleep first, then supply, latch, disable, off-time
    if (!en_eff) begin
      nxt_state = HBGC_SLEEP; // [R04]
    end else if (sense.uv) begin
      nxt_state = HBGC_UVLO; // [R07]
    end else if (nxt_sc_latched || nxt_ot_latched) begin
      nxt_state = HBGC_LATCHED; // [R08]
    end else if (disabled) begin
      nxt_state = HBGC_DISABLED; // [R03] [R05]
    end else if (off_start || off_busy) begin
      nxt_state = HBGC_OFFTIME; // [R11]
    end else begin
      nxt_state = HBGC_DRIVE; // [R10]
    end
    case (nxt_state)
      HBGC_SLEEP: begin
        nxt_flag_low = 1'b0; // [R04]
      end
      HBGC_UVLO, HBGC_LATCHED, HBGC_DISABLED: begin
        nxt_flag_low = 1'b1; // [R05] [R07] [R08] [R15]
      end
      HBGC_OFFTIME: begin
        nxt_flag_low = 1'b0;
      end
      HBGC_DRIVE: begin
        nxt_drv.oe_a = 1'b1; // [R01]
        nxt_drv.oe_b = 1'b1;
        nxt_drv.lvl_a = cmd_a_eff ^ swap_eff; // [R01] [R02]
        nxt_drv.lvl_b = cmd_b_eff ^ swap_eff; // [R01] [R02]
      end
      default: begin
        nxt_flag_low = 1'b1;
      end
    endcase
  end

  // Any newly driven or changed half counts as a transition
  assign blank_start = (nxt_drv.oe_a & (~drv_ff.oe_a | (nxt_drv.lvl_a ^ drv_ff.lvl_a))) |
                       (nxt_drv.oe_b & (~drv_ff.oe_b | (nxt_drv.lvl_b ^ drv_ff.lvl_b))); // [R16]

  // Stage registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= HBGC_SLEEP;
      drv_ff <= '0;
      sc_latched_ff <= 1'b0;
      ot_latched_ff <= 1'b0;
      d_hi_prev_ff <= 1'b1;
      d_lo_prev_ff <= 1'b0;
      flag_low_ff <= 1'b0;
      fold_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      drv_ff <= nxt_drv;
      sc_latched_ff <= nxt_sc_latched;
      ot_latched_ff <= nxt_ot_latched;
      d_hi_prev_ff <= d_hi_eff;
      d_lo_prev_ff <= d_lo_eff;
      flag_low_ff <= nxt_flag_low;
      fold_ff <= sense.temp_fold; // [R12]
    end
  end

  // Pin drivers; flag is open drain
  assign bridge_out_a_o = drv_ff.lvl_a;
  assign bridge_out_a_oe = drv_ff.oe_a;
  assign bridge_out_b_o = drv_ff.lvl_b;
  assign bridge_out_b_oe = drv_ff.oe_b;
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_n_oe = flag_low_ff;
  assign current_limit_reduced = fold_ff; // [R12]

  ////////////////////////////////////////////////////////////////
  // Event status, mask and read port
  logic [`HBGC_EV_W-1:0] status_ff; // Sticky events
  logic [`HBGC_EV_W-1:0] nxt_status;
  logic [`HBGC_EV_W-1:0] mask_ff; // Interrupt enables
  logic [`HBGC_EV_W-1:0] nxt_mask;
  logic [`HBGC_EV_W-1:0] events; // Event pulses
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  always_comb begin
    events = '0;
    events[`HBGC_EV_UV] = en_eff & sense.uv & (state_ff != HBGC_UVLO);
    events[`HBGC_EV_SC] = sc_set & ~sc_latched_ff;
    events[`HBGC_EV_OT] = ot_set & ~ot_latched_ff;
    events[`HBGC_EV_CURRENT_LIMIT_THRESHOLD] = off_start;
    events[`HBGC_EV_CLR] = clr_edge & awake_ok & (sc_latched_ff | ot_latched_ff);
  end

  // Write one to clear, new events win
  always_comb begin
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    nxt_rdata = '0;
    if (bus.wr && bus.addr == `HBGC_ADDR_STATUS) begin
      nxt_status = status_ff & ~bus.wdata[`HBGC_EV_W-1:0];
    end else if (bus.wr && bus.addr == `HBGC_ADDR_MASK) begin
      nxt_mask = bus.wdata[`HBGC_EV_W-1:0];
    end
    nxt_status = nxt_status | events;
    if (bus.rd && bus.addr == `HBGC_ADDR_STATUS) begin
      nxt_rdata = {27'h0000000, status_ff};
    end else if (bus.rd && bus.addr == `HBGC_ADDR_MASK) begin
      nxt_rdata = {27'h0000000, mask_ff};
    end else if (bus.rd && bus.addr == `HBGC_ADDR_STATE) begin
      nxt_rdata = {16'h0000, 2'h0, fold_ff, flag_low_ff, ot_latched_ff, sc_latched_ff,
                   state_ff, drv_ff};
    end
  end

  // Register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_ff <= `HBGC_STATUS_RST;
      mask_ff <= `HBGC_MASK_RST;
      rdata_ff <= 32'h00000000;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  assign irq = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////
  // Checks
  logic [`HBGC_TMR_W-1:0] off_len_ff; // Length of current off-time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_len_ff <= '0;
    end else if (off_start) begin
      off_len_ff <= '0;
    end else if (off_busy) begin
      off_len_ff <= off_len_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sleep_tristate_a: assert property (!en_eff |=> !bridge_out_a_oe && !bridge_out_b_oe && !fault_flag_n_oe) // [R04]
    else $error("sleep did not tri-state");
  disable_flag_a: assert property (en_eff && !sense.uv && disabled |=> fault_flag_n_oe && !bridge_out_a_oe
    && !bridge_out_b_oe) // [R05]
    else $error("disable state wrong");
  follow_cmd_a: assert property (state_ff == HBGC_DRIVE |-> bridge_out_a_oe
    && bridge_out_a_o == $past(cmd_a_eff ^ swap_eff) && bridge_out_b_o == $past(cmd_b_eff ^ swap_eff)) // [R01]
    else $error("outputs do not follow commands");
  uv_lockout_a: assert property (en_eff && sense.uv ##1 en_eff && !sense.uv && !nxt_sc_latched && !nxt_ot_latched
    && !disabled && !off_busy |=> state_ff == HBGC_DRIVE && !fault_flag_n_oe) // [R07]
    else $error("undervoltage recovery wrong");
  short_latch_a: assert property (sc_set |=> sc_latched_ff && fault_flag_n_oe && !bridge_out_a_oe) // [R08]
    else $error("short not latched");
  clear_edge_a: assert property (sc_latched_ff && !ot_latched_ff && clr_edge && awake_ok && !sc_set && !ot_set
    |=> !sc_latched_ff) // [R09]
    else $error("clear edge ignored");
  off_len_a: assert property ($fell(off_busy) |-> off_len_ff == OFF_LEN[`HBGC_TMR_W-1:0]) // [R11]
    else $error("off-time length wrong");
  fold_sel_a: assert property (sense.temp_fold |=> current_limit_reduced) // [R12]
    else $error("reduced limit not selected");
  ot_hold_a: assert property (ot_latched_ff && awake_ok && !sense.temp_cool |=> ot_latched_ff) // [R14]
    else $error("hot latch released");
  blank_run_a: assert property (blank_start |=> blank_busy) // [R16]
    else $error("blanking not started");

  off_seen_c: cover property (off_start ##1 state_ff == HBGC_OFFTIME);
  short_seen_c: cover property (sc_set ##1 sc_latched_ff);
  clear_seen_c: cover property (sc_latched_ff && clr_edge ##1 !sc_latched_ff);
  uv_seen_c: cover property (state_ff == HBGC_UVLO ##1 state_ff == HBGC_DRIVE);

endmodule
`default_nettype wire

// file: sim/hbgc_host.sv
// Purpose: Host controller model driving the control pins
// Assumes: Pins change by non-blocking assignment after a rising edge
// Notes: Flag line has a pull-up, so a released flag reads high
`timescale 1ns/1ns
`default_nettype none
module hbgc_host
  import hbgc_pkg::*;
(
  input wire logic clk,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe,
  output var hbgc_pins_t pins,
  output logic fault_flag_n
);
  // Last levels {en,dis_hi,dis_lo,cmd_a,cmd_b,swap}
  logic [5:0] cur = 6'h00;
  // Open-drain flag resolved with the pull-up
  assign fault_flag_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  // All pins floating at power-up
  initial begin
    pins = 12'h555;
  end
  ////////////////////////////////////////////////////////////////
  // Drive levels, fl marks pins left floating
  task automatic put(input logic [5:0] lv, input logic [5:0] fl);
    hbgc_pins_t p;
    for (int i = 0; i < 6; i++) begin
      p[2*i+1] = lv[i];
      p[2*i] = fl[i];
    end
    @(posedge clk);
    pins <= p;
    cur = lv;
  endtask
  // Clear edge: high-side disable falls
  task automatic clear_hi();
    put(cur | 6'h10, 6'h00);
    put(cur & 6'h2F, 6'h00);
  endtask
  // Clear edge: low-side disable rises
  task automatic clear_lo();
    put(cur & 6'h37, 6'h00);
    put(cur | 6'h08, 6'h00);
  endtask
endmodule
`default_nettype wire

// file: sim/hbridge_gate_control_fault_latch_tb.sv
// Purpose: Self-checking bench of the gate control block
// Assumes: Short off-time and blanking counts for simulation
// Notes: Each scenario task drives and judges on its own
`timescale 1ns/1ns
`default_nettype none
module hbridge_gate_control_fault_latch_tb
  import hbgc_pkg::*;
;
  localparam int OFF = 20; // Off-time cycles
  localparam int BLK = 5; // Blanking cycles
  localparam logic [5:0] FWD = 6'h2C; // Enabled, forward
  logic clk = 1'b0;
  logic rst = 1'b1;
  hbgc_pins_t pins;
  hbgc_sense_t sense = '{uv: 1'b0, cur_over: 1'b0, temp_fold: 1'b0, temp_shut: 1'b0, temp_cool: 1'b1};
  hbgc_bus_t bus = '{addr: 8'h00, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
  logic [31:0] rdata;
  logic irq, a_o, a_oe, b_o, b_oe, f_o, f_oe, lim_red, flag;
  int miscompares = 0;
  int total_checks = 0;
  // Visible drive {oe_a,a,oe_b,b}, Z reads as zero
  wire [3:0] drv = {a_oe, a_oe & a_o, b_oe, b_oe & b_o};
  ////////////////////////////////////////////////////////////////
  hbgc_top #(.OFF_CYC(OFF), .BLANK_CYC(BLK)) hbgc_top_inst (.clk(clk), .rst(rst), .pins(pins), .sense(sense),
    .bus(bus), .rdata(rdata), .irq(irq), .bridge_out_a_o(a_o), .bridge_out_a_oe(a_oe), .bridge_out_b_o(b_o),
    .bridge_out_b_oe(b_oe), .fault_flag_n_o(f_o), .fault_flag_n_oe(f_oe), .current_limit_reduced(lim_red));
  hbgc_host hbgc_host_inst (.clk(clk), .fault_flag_n_o(f_o), .fault_flag_n_oe(f_oe), .pins(pins),
    .fault_flag_n(flag));
  // Clock
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic go(input logic [5:0] lv, input logic [5:0] fl);
    hbgc_host_inst.put(lv, fl);
    step(2);
  endtask
  // Outputs and flag seen together
  task automatic out(input logic [3:0] e, input logic ef);
    chk(drv, e);
    chk(flag, ef);
  endtask
  ////////////////////////////////////////////////////////////////
  // Commands, swap and all four bridge states
  task automatic t_truth();
    for (int i = 0; i < 8; i++) begin
      go({3'b101, i[2:0]}, 6'h00);
      out({1'b1, i[2] ^ i[0], 1'b1, i[1] ^ i[0]}, 1'b1);
    end
  endtask
  // Disables, sleep and floating defaults
  task automatic t_disable();
    go(6'h3C, 6'h00);
    out(4'h0, 1'b0);
    go(6'h24, 6'h00);
    out(4'h0, 1'b0);
    go(FWD, 6'h10);
    out(4'h0, 1'b0);
    go(6'h28, 6'h04);
    out(4'hE, 1'b1);
    go(6'h2D, 6'h01);
    out(4'hE, 1'b1);
    go(FWD, 6'h20);
    out(4'h0, 1'b1);
    go(6'h0C, 6'h00);
    out(4'h0, 1'b1);
  endtask
  // Undervoltage recovers by itself
  task automatic t_uv();
    logic [31:0] d;
    go(FWD, 6'h00);
    wr(8'h00, 32'h1F);
    sense.uv <= 1'b1;
    step(2);
    out(4'h0, 1'b0);
    sense.uv <= 1'b0;
    step(2);
    out(4'hE, 1'b1);
    rd(8'h00, d);
    chk(d & 32'h1, 32'h1);
    chk(irq, 1'b0);
  endtask
  // Limit after blanking: fixed off-time, then resume
  task automatic t_current_limit_threshold();
    logic [31:0] d;
    int n;
    wr(8'h04, 32'h08);
    go(FWD, 6'h00);
    step(BLK + 5);
    sense.cur_over <= 1'b1;
    @(posedge clk);
    sense.cur_over <= 1'b0;
    #1;
    n = 0;
    while (a_oe === 1'b0 && n < 100) begin
      n++;
      step(1);
    end
    chk(n, OFF);
    out(4'hE, 1'b1);
    chk(irq, 1'b1);
    rd(8'h00, d);
    chk(d & 32'h8, 32'h8);
    wr(8'h00, 32'h08);
    step(1);
    chk(irq, 1'b0);
  endtask
  // Limit inside blanking latches, clear edges release
  task automatic t_short(input bit lo);
    logic [31:0] d;
    wr(8'h00, 32'h1F);
    go(FWD, 6'h00);
    step(BLK + 5);
    hbgc_host_inst.put(6'h2A, 6'h00);
    @(posedge clk);
    sense.cur_over <= 1'b1;
    @(posedge clk);
    sense.cur_over <= 1'b0;
    step(2);
    out(4'h0, 1'b0);
    go(FWD, 6'h00);
    out(4'h0, 1'b0);
    if (lo) begin
      hbgc_host_inst.clear_lo();
    end else begin
      hbgc_host_inst.clear_hi();
    end
    step(2);
    out(4'hE, 1'b1);
    rd(8'h00, d);
    chk(d & 32'h12, 32'h12);
  endtask
  // Overtemperature needs cooling; enable toggle also clears
  task automatic t_ot();
    sense <= '{uv: 1'b0, cur_over: 1'b0, temp_fold: 1'b1, temp_shut: 1'b1, temp_cool: 1'b0};
    @(posedge clk);
    sense.temp_shut <= 1'b0;
    step(2);
    out(4'h0, 1'b0);
    chk(lim_red, 1'b1);
    hbgc_host_inst.clear_lo();
    step(2);
    out(4'h0, 1'b0);
    sense.temp_cool <= 1'b1;
    sense.temp_fold <= 1'b0;
    hbgc_host_inst.clear_lo();
    step(2);
    out(4'hE, 1'b1);
    chk(lim_red, 1'b0);
    sense.temp_shut <= 1'b1;
    @(posedge clk);
    sense.temp_shut <= 1'b0;
    step(1);
    out(4'h0, 1'b0);
    go(6'h0C, 6'h00);
    go(FWD, 6'h00);
    out(4'hE, 1'b1);
  endtask
  // Read-only state view, unmapped place, mask, w1c
  task automatic t_regs();
    logic [31:0] d;
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, d);
    chk(d, 32'h20E);
    rd(8'h0C, d);
    chk(d, 32'h0);
    wr(8'h04, 32'h1F);
    rd(8'h04, d);
    chk(d, 32'h1F);
    wr(8'h00, 32'h1F);
    rd(8'h00, d);
    chk(d, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    step(2);
    out(4'h0, 1'b1);
    chk(rdata, 32'h0);
    chk({30'h0, irq, lim_red}, 32'h0);
    repeat (18) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, d);
    chk(d, 32'h0);
    rd(8'h04, d);
    chk(d, 32'h0);
    t_truth();
    t_disable();
    t_uv();
    t_current_limit_threshold();
    t_short(1'b0);
    t_short(1'b1);
    t_ot();
    go(FWD, 6'h00);
    t_regs();
    end_of_test();
  end
  // Watchdog
  initial begin
    #300000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
